// ===== common/tmc_pkg.sv
// Constants shared by the temperature monitor control and status logic
package tmc_pkg;
  // ----------------------------------------------------------------
  // Register command codes and the unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RD_STATUS = 8'h02;
  localparam logic [7:0] CMD_RD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_RD_RATE = 8'h04;
  localparam logic [7:0] CMD_WR_CONFIG = 8'h09;
  localparam logic [7:0] CMD_WR_RATE = 8'h0A;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STOP_BIT = 6;
  localparam int CFG_PNP_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h20;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hE0;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_FLAG_LSB = 2;
  localparam int STAT_FLAG_W = 5;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam int RATE_CODE_W = 4;
  localparam logic [3:0] RATE_MAX_CODE = 4'h8;
  localparam logic [3:0] RATE_EXT_MAX = 4'h6;
  localparam int RATE_SHIFT_W = 9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 62_500;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int CONV_MAX_US = 156_000;
  localparam int CONV_MAX_CYCLES = (CLK_HZ / 1_000_000) * CONV_MAX_US;
endpackage

// ===== core/tmc_ctrl.sv
// Temperature monitor configuration, status, rate and alarm control
`timescale 1ns/1ps
// How it works
// R1: Mask bit blocks the interrupt output
// R2: Stop bit selects standby, else free-run
// R3: Junction type bit drives measurement path
// R4: Low five config bits read zero
// R5: Status reads busy-only after reset
// R6: Busy bit high during conversion
// R7: Four limit alarm flags set on trip
// R8: Open diode flag sets on fault
// R9: Status read clears flags unless persisting
// R10: Interrupt clears on status read, re-sets at end
// R11: Overheat bits follow first threshold state
// R12: Overheat bits not cleared by reads
// R13: Overheat ends below threshold minus band
// R14: Status omits second overheat output
// R15: Accesses anytime; set beats read clear
// R16: Rate code sets free-run conversion frequency
// R17: Rate register resets to 08h
// R18: Only low rate nibble is decoded
// R19: Extended results only at 4 Hz or slower
// R20: Interval within 25 percent of rate
// R21: Limit trips at equal or greater
// R22: Conversion completes within maximum time
// R23: One-shot ignored while converting
// R24: Flags latched at conversion end
module tmc_ctrl #(
  parameter int TICK_CYCLES = tmc_pkg::TICK_CYCLES,
  parameter int CONV_MAX_CYCLES = tmc_pkg::CONV_MAX_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic signed [7:0] local_temp,
  input wire logic signed [7:0] remote_temp,
  input wire logic diode_open,
  input wire logic signed [7:0] local_upper_limit,
  input wire logic signed [7:0] local_lower_limit,
  input wire logic signed [7:0] remote_upper_limit,
  input wire logic signed [7:0] remote_lower_limit,
  input wire logic signed [7:0] local_overheat1_limit,
  input wire logic signed [7:0] remote_overheat1_limit,
  input wire logic [7:0] return_band,
  output logic substrate_junction_sel,
  output logic extended_allowed,
  output logic alert_o,
  output logic alert_oe_n,
  output logic overheat_out1
);
  import tmc_pkg::*;

  localparam int TW = $clog2(CONV_MAX_CYCLES + 1);
  localparam logic [TW-1:0] CONV_LAST = TW'(CONV_MAX_CYCLES - 1);

  typedef enum logic {
    CS_IDLE,
    CS_CONV
  } tmc_conv_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] rdata;
    logic rvalid;
    tmc_conv_t cs;
    logic busy;
    logic start_pend;
    logic start;
    logic [TW-1:0] conv_cnt;
    logic [STAT_FLAG_W-1:0] flags;
    logic [STAT_FLAG_W-1:0] live;
    logic irq;
    logic alert_oe_n;
    logic local_ot1;
    logic remote_ot1;
    logic ot1_out;
    logic ext_ok;
  } tmc_state_t;

  tmc_state_t s_q;
  tmc_state_t s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Limit trips at or above its threshold
  function automatic logic tmc_at_or_above(input logic signed [7:0] temp,
                                           input logic signed [7:0] lim);
    tmc_at_or_above = (temp >= lim); // R21
  endfunction

  // Overheat hysteresis: set at threshold, clear below threshold minus band
  function automatic logic tmc_ot_next(input logic cur,
                                       input logic signed [7:0] temp,
                                       input logic signed [7:0] lim,
                                       input logic [7:0] band);
    logic signed [9:0] low;
    low = 10'(lim) - $signed({2'b00, band});
    if (temp >= lim) begin
      tmc_ot_next = 1'b1;
    end else if (10'(temp) < low) begin
      tmc_ot_next = 1'b0; // R13
    end else begin
      tmc_ot_next = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  logic iv_due;
  logic iv_restart;
  logic run_mode;
  logic start_ok;

  tmc_interval #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_interval (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .run(run_mode),
    .restart(iv_restart),
    .rate_code(s_q.rate[RATE_CODE_W-1:0]), // R18
    .due(iv_due)
  );

  // Free-run unless the stop bit is set
  assign run_mode = ~s_q.cfg[CFG_STOP_BIT]; // R2

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic rd_status;
  logic oneshot_req;
  logic conv_end;
  logic [STAT_FLAG_W-1:0] new_cond;
  logic [7:0] status_word;

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rvalid = 1'b0;
    rd_status = reg_rd && (reg_cmd == CMD_RD_STATUS);
    oneshot_req = reg_wr && (reg_cmd == CMD_ONE_SHOT);
    conv_end = 1'b0;
    start_ok = 1'b0;
    iv_restart = 1'b0;

    // Alarm conditions from the latest results
    new_cond = {tmc_at_or_above(local_temp, local_upper_limit), // R7
                tmc_at_or_above(local_lower_limit, local_temp),
                tmc_at_or_above(remote_temp, remote_upper_limit),
                tmc_at_or_above(remote_lower_limit, remote_temp),
                diode_open}; // R8

    // Status word; no second overheat output in it
    status_word = {s_q.busy, s_q.flags, s_q.remote_ot1, s_q.local_ot1}; // R6 R11 R14

    // Register writes
    if (reg_wr && reg_cmd == CMD_WR_CONFIG) begin
      s_d.cfg = reg_wdata & CFG_WRITE_MASK; // R4
    end
    if (reg_wr && reg_cmd == CMD_WR_RATE) begin
      s_d.rate = reg_wdata; // R16
    end

    // Register reads, answered one cycle later
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      case (reg_cmd)
        CMD_RD_STATUS: s_d.rdata = status_word;
        CMD_RD_CONFIG: s_d.rdata = s_q.cfg & CFG_WRITE_MASK; // R4
        CMD_RD_RATE: s_d.rdata = s_q.rate;
        default: s_d.rdata = RD_UNMAPPED;
      endcase
    end

    // Conversion sequencing
    case (s_q.cs)
      CS_IDLE: begin
        if (s_q.start_pend || oneshot_req || (iv_due && run_mode)) begin
          start_ok = 1'b1;
          iv_restart = oneshot_req; // R2
        end
      end
      CS_CONV: begin
        if (conv_done || s_q.conv_cnt == CONV_LAST) begin
          conv_end = 1'b1; // R22
        end else begin
          s_d.conv_cnt = s_q.conv_cnt + TW'(1);
        end
      end
      default: begin
        s_d.cs = CS_IDLE;
      end
    endcase
    // A one-shot during a conversion has no effect
    if (start_ok) begin // R23
      s_d.cs = CS_CONV;
      s_d.start = 1'b1;
      s_d.start_pend = 1'b0;
      s_d.busy = 1'b1; // R6
      s_d.conv_cnt = '0;
    end
    if (conv_end) begin
      s_d.cs = CS_IDLE;
      s_d.busy = 1'b0; // R6
    end

    // Read clears flags whose condition no longer holds
    if (rd_status) begin
      s_d.flags = s_q.flags & s_q.live; // R9
      s_d.irq = 1'b0; // R10
    end
    // Conversion end latches flags; a set wins over a same-cycle clear
    if (conv_end) begin
      s_d.live = new_cond; // R24
      s_d.flags = s_d.flags | new_cond; // R15
      if (|new_cond && !s_q.cfg[CFG_MASK_BIT]) begin
        s_d.irq = 1'b1; // R10
      end
    end

    // Overheat tracking, immune to status reads
    s_d.local_ot1 = tmc_ot_next(s_q.local_ot1, local_temp,
                                local_overheat1_limit, return_band); // R12
    s_d.remote_ot1 = tmc_ot_next(s_q.remote_ot1, remote_temp,
                                 remote_overheat1_limit, return_band); // R12
    s_d.ot1_out = s_d.local_ot1 | s_d.remote_ot1;

    // Interrupt pin pulled low only while unmasked
    s_d.alert_oe_n = ~(s_d.irq & ~s_d.cfg[CFG_MASK_BIT]); // R1

    // Extended results only at 4 Hz or slower
    s_d.ext_ok = (s_d.rate[RATE_CODE_W-1:0] <= RATE_EXT_MAX); // R19
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset: conversion pending, busy shown, flags clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET; // R3
      s_q.rate <= RATE_RESET; // R17
      s_q.cs <= CS_IDLE;
      s_q.busy <= 1'b1; // R5
      s_q.start_pend <= 1'b1;
      s_q.alert_oe_n <= 1'b1;
      s_q.ext_ok <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign conv_start = s_q.start;
  assign substrate_junction_sel = s_q.cfg[CFG_PNP_BIT]; // R3
  assign extended_allowed = s_q.ext_ok;
  assign alert_o = 1'b0;
  assign alert_oe_n = s_q.alert_oe_n;
  assign overheat_out1 = s_q.ot1_out;
endmodule // tmc_ctrl

// ===== core/tmc_interval.sv
// Conversion interval timer: fires a due pulse at the programmed rate
`timescale 1ns/1ps
module tmc_interval #(
  parameter int TICK_CYCLES = tmc_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic restart,
  input wire logic [tmc_pkg::RATE_CODE_W-1:0] rate_code,
  output logic due
);
  import tmc_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [RATE_SHIFT_W-1:0] ticks;
    logic due;
  } tmc_iv_t;

  tmc_iv_t s_q;
  tmc_iv_t s_d;
  logic [RATE_CODE_W-1:0] code;
  logic [RATE_SHIFT_W-1:0] span;

  // Reserved codes run at the fastest rate; one tick is 1/16 s
  always_comb begin
    code = (rate_code > RATE_MAX_CODE) ? RATE_MAX_CODE : rate_code;
    span = RATE_SHIFT_W'(1) << (RATE_MAX_CODE - code); // R16 R20
    s_d = s_q;
    s_d.due = 1'b0;
    if (!run || restart) begin
      s_d.pre = '0;
      s_d.ticks = '0;
    end else if (s_q.pre == TICK_LAST) begin
      s_d.pre = '0;
      if (s_q.ticks >= span - RATE_SHIFT_W'(1)) begin
        s_d.ticks = '0;
        s_d.due = 1'b1;
      end else begin
        s_d.ticks = s_q.ticks + RATE_SHIFT_W'(1);
      end
    end else begin
      s_d.pre = s_q.pre + PW'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign due = s_q.due;
endmodule // tmc_interval

// ===== verification/tb_top.sv
// Self-checking bench for the temperature monitor control block
`timescale 1ns/1ps
module tb_top;
  import tmc_pkg::*;
  logic sys_clk = 0, resetn = 0, ce = 1, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [7:0] reg_cmd = 0, reg_wdata = 0, reg_rdata, band = 8'h05;
  logic signed [7:0] t = 8'sd25, hi = 8'sd100, lo = -8'sd128, ot = 8'sd100;
  logic reg_rvalid, conv_start, conv_done, sjs, ext, al, al_oe_n, oh;
  logic dop = 0;
  logic [15:0] q[$];
  logic [15:0] e;
  int err_count = 0, check_count = 0, starts = 0, n, k;
  integer seed = 25464;
  always #5 sys_clk = ~sys_clk;
  tmc_ctrl #(.TICK_CYCLES(20), .CONV_MAX_CYCLES(200)) dut_u (.sys_clk, .resetn, .ce,
    .reg_cmd, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .conv_start,
    .conv_done, .local_temp(t), .remote_temp(t), .diode_open(dop),
    .local_upper_limit(hi), .local_lower_limit(lo), .remote_upper_limit(hi),
    .remote_lower_limit(lo), .local_overheat1_limit(ot), .remote_overheat1_limit(ot),
    .return_band(band), .substrate_junction_sel(sjs), .extended_allowed(ext),
    .alert_o(al), .alert_oe_n(al_oe_n), .overheat_out1(oh));
  tmc_conv_model cm_u (.sys_clk, .resetn, .conv_start, .slow, .conv_done);
  // ----
  // Tasks
  // ----
  task check(input logic [7:0] s, input logic [7:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, s, x);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One strobe cycle, then one idle edge before the next request
  task wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_wr = 1;
    reg_cmd = c;
    reg_wdata = d;
    @(posedge sys_clk);
    #1 reg_wr = 0;
  endtask
  task rd(input logic [7:0] c, input logic [7:0] x, input logic [7:0] m);
    @(posedge sys_clk);
    #1 reg_rd = 1;
    reg_cmd = c;
    q.push_back({m, x & m});
    @(posedge sys_clk);
    #1 reg_rd = 0;
  endtask
  task conv();
    wr(CMD_ONE_SHOT, 8'h00);
    n = 0;
    while (conv_done !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check(8'(n < 300), 1);
    repeat (3) @(posedge sys_clk);
  endtask
  // Third wait, from the second start to the third, is a full interval at the new code
  task gap(input logic [7:0] c, input int p);
    wr(CMD_WR_RATE, c);
    rd(CMD_RD_RATE, c, 8'hFF);
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (conv_start !== 1'b1 && n < 1000);
    end
    check(8'(n >= p * 3 / 4 && n <= p * 5 / 4), 1);
  endtask
  // Scoreboard takes the oldest note at each read answer
  always @(negedge sys_clk) begin
    if (conv_start === 1'b1) starts++;
    if (reg_rvalid === 1'b1) begin
      check(8'(q.size() > 0), 1);
      e = q.pop_front();
      check(reg_rdata & e[15:8], e[7:0]);
    end
  end
  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1;
    rd(CMD_RD_STATUS, 8'h80, 8'hFF);
    rd(CMD_RD_CONFIG, 8'h20, 8'hFF);
    rd(CMD_RD_RATE, 8'h08, 8'hFF);
    rd(8'h01, RD_UNMAPPED, 8'hFF);
    check(sjs, 1);
    check(al, 0);
    $display("test reset finished");
    gap(8'h06, 80);
    check(ext, 1);
    gap(8'h07, 40);
    gap(8'h18, 20);
    gap(8'h09, 20);
    gap(8'h08, 20);
    check(ext, 0);
    $display("test rate finished");
    wr(CMD_WR_CONFIG, {3'b010, 5'($random(seed))});
    rd(CMD_RD_CONFIG, 8'h40, 8'hFF);
    k = starts;
    repeat (100) @(posedge sys_clk);
    check(8'(starts - k), 0);
    check(sjs, 0);
    #1;
    hi = 8'sd30;
    t = 8'sd30;
    conv();
    check(al_oe_n, 0);
    rd(CMD_RD_STATUS, 8'h50, 8'hFF);
    hi = 8'sd100;
    rd(CMD_RD_STATUS, 8'h50, 8'hFF);
    conv();
    rd(CMD_RD_STATUS, 8'h50, 8'hFF);
    rd(CMD_RD_STATUS, 8'h00, 8'hFF);
    wr(CMD_WR_CONFIG, 8'hC0);
    hi = 8'sd30;
    conv();
    check(al_oe_n, 1);
    #1;
    hi = 8'sd100;
    wr(CMD_WR_CONFIG, 8'h40);
    $display("test alarm finished");
    ot = 8'sd20;
    t = 8'sd30;
    repeat (3) @(posedge sys_clk);
    check(oh, 1);
    rd(CMD_RD_STATUS, 8'h03, 8'h03);
    check(oh, 1);
    #1;
    t = 8'sd17;
    repeat (3) @(posedge sys_clk);
    check(oh, 1);
    #1;
    t = 8'sd14;
    repeat (3) @(posedge sys_clk);
    check(oh, 0);
    rd(CMD_RD_STATUS, 8'h00, 8'h03);
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      #1 t = 8'($random(seed));
    end
    t = 8'sd25;
    ot = 8'sd100;
    $display("test overheat finished");
    dop = 1;
    conv();
    check(al_oe_n, 0);
    rd(CMD_RD_STATUS, 8'h04, 8'h04);
    dop = 0;
    conv();
    rd(CMD_RD_STATUS, 8'h04, 8'h04);
    rd(CMD_RD_STATUS, 8'h00, 8'h04);
    $display("test diode finished");
    k = starts;
    slow = 1;
    wr(CMD_ONE_SHOT, 8'h00);
    rd(CMD_RD_STATUS, 8'h80, 8'h80);
    conv();
    check(8'(starts - k), 1);
    #1;
    slow = 0;
    $display("test busy finished");
    report_and_stop();
  end
endmodule // tb_top

// ===== verification/tmc_conv_model.sv
// Converter stand-in that answers each start pulse with a done pulse
`timescale 1ns/1ps
module tmc_conv_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic conv_start,
  input wire logic slow,
  output logic conv_done
);
  int cnt_q;
  // Done after 5 cycles, or 60 when slow, well inside the timeout
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_q == 1);
      if (conv_start) begin
        cnt_q <= slow ? 60 : 5;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule // tmc_conv_model

// ===== verification/tmc_ctrl_props.sv
// Assertion checker for the temperature monitor control block
`timescale 1ns/1ps
module tmc_ctrl_props import tmc_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic signed [7:0] local_temp,
  input wire logic signed [7:0] local_overheat1_limit,
  input wire logic substrate_junction_sel,
  input wire logic extended_allowed,
  input wire logic alert_oe_n,
  input wire logic overheat_out1
);
  logic m_q, b_q;
  logic [3:0] r_q;
  // Shadow of mask bit, rate nibble and conversion in flight
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      m_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= RATE_RESET[3:0];
    end else if (ce) begin
      if (reg_wr && reg_cmd == CMD_WR_CONFIG) m_q <= reg_wdata[7];
      if (reg_wr && reg_cmd == CMD_WR_RATE) r_q <= reg_wdata[3:0];
      if (conv_start) b_q <= 1'b1;
      else if (conv_done) b_q <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  rd_answer_a: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!(ce && reg_rd) |=> !reg_rvalid)
    else $error("spurious read valid");
  cfg_read_a: assert property (ce && reg_rd && reg_cmd == CMD_RD_CONFIG
    |=> reg_rdata[4:0] == 5'h00 && reg_rdata[5] == substrate_junction_sel && reg_rdata[7] == m_q)
    else $error("config read wrong");
  mask_hides_a: assert property (m_q && $past(m_q) |-> alert_oe_n)
    else $error("alert while masked");
  rd_clears_a: assert property (ce && reg_rd && reg_cmd == CMD_RD_STATUS && !conv_done
    |=> alert_oe_n) else $error("alert kept after status read");
  one_shot_a: assert property (conv_start |-> !b_q)
    else $error("start while converting");
  ext_rate_a: assert property ($stable(r_q) |-> extended_allowed == (r_q <= RATE_EXT_MAX))
    else $error("extended flag wrong");
  heat_set_a: assert property (ce && local_temp >= local_overheat1_limit |=> overheat_out1)
    else $error("overheat not raised");
  cover property (conv_start ##[1:100] conv_done);
  cover property (!alert_oe_n);
  cover property (overheat_out1 && reg_rvalid);
endmodule // tmc_ctrl_props
bind tmc_ctrl tmc_ctrl_props u_props (.sys_clk, .resetn, .ce, .reg_cmd, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .reg_rvalid, .conv_start, .conv_done, .local_temp,
  .local_overheat1_limit, .substrate_junction_sel, .extended_allowed, .alert_oe_n,
  .overheat_out1);
